// [hw/fmsp_pkg.sv]
// Package: constants and types for the flash mode/suspend/sleep control
package fmsp_pkg;
    // Opcodes
    localparam logic [7:0] OP_QUAD_ENTRY = 8'h35;
    localparam logic [7:0] OP_QUAD_EXIT = 8'hF5;
    localparam logic [7:0] OP_SUSPEND_A = 8'h75;
    localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
    localparam logic [7:0] OP_RESUME_A = 8'h7A;
    localparam logic [7:0] OP_RESUME_B = 8'h30;
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_ID = 8'hAB;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_FUNC_READ = 8'h48;
    localparam logic [7:0] OP_FUNC_WRITE = 8'h42;
    localparam logic [7:0] OP_SERIAL_PAGE = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_A = 8'h32;
    localparam logic [7:0] OP_QUAD_PAGE_B = 8'h38;
    localparam logic [7:0] OP_SECTOR_ER_A = 8'hD7;
    localparam logic [7:0] OP_SECTOR_ER_B = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ER = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ER = 8'hD8;
    localparam logic [7:0] OP_CHIP_ER_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ER_B = 8'h60;
    // AHB-Lite register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_FUNC = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_LASTOP = 8'h0C;
    // Field positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_WLATCH = 1;
    localparam int BIT_PROGRAM_SUSPENDED_FLAG = 2;
    localparam int BIT_ERASE_SUSPENDED_FLAG = 3;
    localparam int BIT_QUAD = 4;
    localparam int BIT_SLEEP = 5;
    localparam int BIT_CTL_DONE = 0;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int SUSPEND_US = 100;
    localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
    localparam int SLEEP_ENTRY_US = 3;
    localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
    localparam int WAKE_US = 5;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // Kinds of internal operation
    typedef enum logic [1:0] {OPK_NONE, OPK_PROG, OPK_ERASE,
        OPK_CHIP} fmsp_opk_t;
    // Serial pins after synchronisation
    typedef struct packed {
        logic sel_n;
        logic sck;
        logic [3:0] io;
    } fmsp_pins_t;
    // Condensed status
    typedef struct packed {
        logic sleep;
        logic quad;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic wlatch;
        logic busy;
    } fmsp_stat_t;
endpackage

// [hw/fmsp_ctrl.sv]
// Flash command-state control: quad mode, suspend/resume, deep sleep
`timescale 1ns/1ps
// Overview of operation
// - Quad entry makes commands four bits wide
// - Quad exit returns to one-bit commands
// - Quad exit only in quad two-clock form
// - Both suspend and resume opcodes, both modes
// - Function bits 2,3 show suspend flags
// - Ready for reads within suspend time
// - Suspend ignored during chip erase
// - Erase suspend rejects status writes, erases
// - Erase suspend sets flag, busy until ready
// - Any suspend flag clears write latch
// - Program suspend rejects status writes, programs
// - Program suspend sets flag, busy until ready
// - Resume restarts operation, clears flag
// - Array reads allowed during any suspend
// - Erase suspend also allows program, latch
// - Register reads, ids, reset allowed suspended
// - Deep sleep ignores write, program, erase
// - Sleep engages after select rises, timed
// - Asleep only wake opcode is recognised
// - Sleep accepted in both command modes
// - Wake delayed; ignored while busy
// - Busy reads one during program or erase
module fmsp_ctrl
    import fmsp_pkg::*;
#(
    parameter int SUSPEND_CYCLES = SUSPEND_CYC,
    parameter int SLEEP_CYCLES = SLEEP_ENTRY_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    // Serial pins from the host
    input wire logic I_SEL_N,
    input wire logic I_SCK,
    input wire logic [3:0] I_IO,
    // Engine: start of a self-timed operation and its end
    input wire logic I_ENG_DONE,
    output logic O_ENG_RUN,
    output logic [1:0] O_ENG_KIND,
    // Accepted opcode strobe toward read/program datapaths
    output logic O_CMD_VALID,
    output logic [7:0] O_CMD_CODE,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    typedef enum {ST_IDLE, ST_RUN, ST_SUSPENDING, ST_SUSPENDED}
        eng_st_t;
    typedef enum {SL_AWAKE, SL_ENTER, SL_ASLEEP, SL_WAKING} slp_st_t;

    // Two-flop synchronisers on the pins
    fmsp_pins_t pin_m_q, pin_s_q;
    logic sck_d1_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            // Idle levels: deselected, clock low, so no false edge
            pin_m_q <= '{sel_n: 1'b1, sck: 1'b0, io: 4'h0};
            pin_s_q <= '{sel_n: 1'b1, sck: 1'b0, io: 4'h0};
            sck_d1_q <= 1'b0;
        end else begin
            pin_m_q <= {I_SEL_N, I_SCK, I_IO};
            pin_s_q <= pin_m_q;
            sck_d1_q <= pin_s_q.sck;
        end
    end
    wire sck_rise = pin_s_q.sck & ~sck_d1_q;
    logic sel_d1_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) sel_d1_q <= 1'b1;
        else sel_d1_q <= pin_s_q.sel_n;
    end
    wire frame_end = pin_s_q.sel_n & ~sel_d1_q;

    // Mode, flags, state
    logic quad_command_mode_q;
    logic program_suspended_flag_q, erase_suspended_flag_q;
    logic write_latch_q;
    fmsp_opk_t op_kind_q;
    eng_st_t eng_q;
    slp_st_t slp_q;
    logic [16:0] tmr_q;
    wire busy_flag = (eng_q == ST_RUN) || (eng_q == ST_SUSPENDING);

    // Opcode shifter: bits or nibbles, high first
    logic [7:0] shift_q;
    logic [3:0] nclk_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            shift_q <= 8'h00;
            nclk_q <= 4'h0;
        end else if (pin_s_q.sel_n) begin
            nclk_q <= 4'h0;
        end else if (sck_rise && nclk_q != 4'hF) begin
            nclk_q <= nclk_q + 4'h1;
            if (nclk_q < 4'h8) begin
                if (quad_command_mode_q)
                    shift_q <= {shift_q[3:0], pin_s_q.io};
                else
                    shift_q <= {shift_q[6:0], pin_s_q.io[0]};
            end
        end
    end
    // Opcode complete when select rises after at least the mode's clock count
    wire [3:0] need_clk = quad_command_mode_q ? 4'h2 : 4'h8;
    wire op_done = frame_end && nclk_q >= need_clk;
    wire [7:0] op = shift_q;
    // Quad exit requires exactly the two-clock quad cycle
    wire exact_len = nclk_q == need_clk;

    function automatic logic allowed_suspended(input logic [7:0] c,
            input logic erase_susp);
        logic base;
        base = 1'b0;
        case (c)
            8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD,
            8'hED: base = 1'b1;
            8'h05, 8'h48, 8'h82, 8'h7A, 8'h30, 8'hAB, 8'hC0, 8'h63,
            8'h83, 8'h61, 8'h81, 8'h9F, 8'h90, 8'hAF, 8'h4B, 8'h5A,
            8'h00, 8'h66, 8'h99, 8'h68, 8'h14: base = 1'b1;
            8'h02, 8'h32, 8'h38, 8'h06, 8'h26, 8'h24, 8'h75,
            8'hB0: base = erase_susp;
            default: base = 1'b0;
        endcase
        return base;
    endfunction

    function automatic logic is_erase(input logic [7:0] c);
        return c == OP_SECTOR_ER_A || c == OP_SECTOR_ER_B ||
            c == OP_BLOCK32_ER || c == OP_BLOCK64_ER ||
            c == OP_CHIP_ER_A || c == OP_CHIP_ER_B;
    endfunction

    function automatic logic is_prog(input logic [7:0] c);
        return c == OP_SERIAL_PAGE || c == OP_QUAD_PAGE_A ||
            c == OP_QUAD_PAGE_B;
    endfunction

    // Acceptance filter
    wire suspended = eng_q == ST_SUSPENDED;
    wire asleep = slp_q != SL_AWAKE;
    // Either opcode of each pair, in both command widths
    wire is_susp_op = op == OP_SUSPEND_A || op == OP_SUSPEND_B;
    wire is_res_op = op == OP_RESUME_A || op == OP_RESUME_B;
    logic accept;
    always_comb begin
        accept = op_done;
        if (slp_q == SL_ASLEEP)
            accept = op_done && op == OP_WAKE_ID
                && !busy_flag;
        else if (asleep)
            accept = 1'b0;
        else if (eng_q == ST_SUSPENDING)
            accept = 1'b0;
        else if (suspended)
            accept = op_done && allowed_suspended(op, erase_suspended_flag_q)
                && !(op == OP_STATUS_WRITE)
                && !is_erase(op)
                && !(program_suspended_flag_q && is_prog(op));
        // Suspend during chip erase is dropped, not even strobed out
        else if (is_susp_op && op_kind_q == OPK_CHIP)
            accept = 1'b0;
    end

    // Accepted opcode strobe
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_CMD_VALID <= 1'b0;
            O_CMD_CODE <= 8'h00;
        end else begin
            O_CMD_VALID <= accept;
            if (accept) O_CMD_CODE <= op;
        end
    end

    // Command width mode; sleep-independent, cleared by I_RESET or an exact quad exit
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) quad_command_mode_q <= 1'b0;
        else if (accept && op == OP_QUAD_ENTRY && !quad_command_mode_q)
            quad_command_mode_q <= 1'b1;
        else if (accept && op == OP_QUAD_EXIT && quad_command_mode_q &&
                exact_len)
            quad_command_mode_q <= 1'b0;
    end

    // Engine sequencing: run, suspend, resume
    logic eng_start;
    always_comb begin
        eng_start = accept && eng_q == ST_IDLE && write_latch_q &&
            (is_prog(op) || is_erase(op));
    end
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            eng_q <= ST_IDLE;
            op_kind_q <= OPK_NONE;
            program_suspended_flag_q <= 1'b0;
            erase_suspended_flag_q <= 1'b0;
            tmr_q <= '0;
        end else begin
            case (eng_q)
                ST_IDLE: begin
                    if (eng_start) begin
                        eng_q <= ST_RUN;
                        op_kind_q <= is_prog(op) ? OPK_PROG :
                            (op == OP_CHIP_ER_A || op == OP_CHIP_ER_B) ?
                            OPK_CHIP : OPK_ERASE;
                    end
                end
                ST_RUN: begin
                    if (I_ENG_DONE) begin
                        eng_q <= ST_IDLE;
                        op_kind_q <= OPK_NONE;
                    end else if (accept && is_susp_op &&
                            op_kind_q != OPK_CHIP) begin
                        eng_q <= ST_SUSPENDING;
                        tmr_q <= 17'(SUSPEND_CYCLES - 1);
                        if (op_kind_q == OPK_PROG)
                            program_suspended_flag_q <= 1'b1;
                        else
                            erase_suspended_flag_q <= 1'b1;
                    end
                end
                ST_SUSPENDING: begin
                    if (tmr_q == '0) eng_q <= ST_SUSPENDED;
                    else tmr_q <= tmr_q - 17'd1;
                end
                ST_SUSPENDED: begin
                    if (accept && is_res_op) begin
                        eng_q <= ST_RUN;
                        program_suspended_flag_q <= 1'b0;
                        erase_suspended_flag_q <= 1'b0;
                    end
                end
                default: eng_q <= ST_IDLE;
            endcase
        end
    end
    assign O_ENG_RUN = eng_q == ST_RUN;
    assign O_ENG_KIND = op_kind_q;

    // Write latch: set by command, cleared by suspend or completion
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) write_latch_q <= 1'b0;
        else if (eng_q == ST_RUN && accept && is_susp_op &&
                op_kind_q != OPK_CHIP)
            write_latch_q <= 1'b0;
        else if (eng_start || (eng_q == ST_RUN && I_ENG_DONE) ||
                (accept && op == OP_LATCH_CLR))
            write_latch_q <= 1'b0;
        else if (accept && op == OP_LATCH_SET)
            write_latch_q <= 1'b1;
    end

    // Deep sleep entry and wake timing
    logic [16:0] stmr_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            slp_q <= SL_AWAKE;
            stmr_q <= '0;
        end else begin
            case (slp_q)
                SL_AWAKE: begin
                    if (accept && op == OP_SLEEP && !suspended) begin
                        slp_q <= SL_ENTER;
                        stmr_q <= 17'(SLEEP_CYCLES - 1);
                    end
                end
                SL_ENTER: begin
                    if (stmr_q == '0) slp_q <= SL_ASLEEP;
                    else stmr_q <= stmr_q - 17'd1;
                end
                SL_ASLEEP: begin
                    if (accept) begin
                        slp_q <= SL_WAKING;
                        stmr_q <= 17'(WAKE_CYCLES - 1);
                    end
                end
                SL_WAKING: begin
                    if (stmr_q == '0) slp_q <= SL_AWAKE;
                    else stmr_q <= stmr_q - 17'd1;
                end
                default: slp_q <= SL_AWAKE;
            endcase
        end
    end

    // Status packed for the register file
    fmsp_stat_t stat;
    assign stat = '{sleep: asleep, quad: quad_command_mode_q,
        erase_suspended_flag: erase_suspended_flag_q, program_suspended_flag: program_suspended_flag_q,
        wlatch: write_latch_q, busy: busy_flag};

    // AHB-Lite: zero-wait slave, address captured for the data phase
    logic ph_valid_q, ph_write_q;
    logic [7:0] ph_addr_q;
    logic ctl_done_q;
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (HREADY) begin
            ph_valid_q <= HSEL && HTRANS[1];
            ph_write_q <= HWRITE;
            ph_addr_q <= HADDR[7:0];
        end
    end
    // Control word: sticky mask of done indication, software owned
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) ctl_done_q <= 1'b0;
        else if (ph_valid_q && ph_write_q && ph_addr_q == REG_CTRL)
            ctl_done_q <= HWDATA[BIT_CTL_DONE];
    end
    always_comb begin
        HRDATA = RESET_WORD;
        if (ph_valid_q && !ph_write_q) begin
            case (ph_addr_q)
                REG_STATUS: begin
                    HRDATA[BIT_BUSY] = stat.busy;
                    HRDATA[BIT_WLATCH] = stat.wlatch;
                    HRDATA[BIT_QUAD] = stat.quad;
                    HRDATA[BIT_SLEEP] = stat.sleep;
                end
                REG_FUNC: begin
                    HRDATA[BIT_PROGRAM_SUSPENDED_FLAG] = stat.program_suspended_flag;
                    HRDATA[BIT_ERASE_SUSPENDED_FLAG] = stat.erase_suspended_flag;
                end
                REG_CTRL: HRDATA[BIT_CTL_DONE] = ctl_done_q;
                REG_LASTOP: HRDATA[7:0] = O_CMD_CODE;
                default: HRDATA = RESET_WORD;
            endcase
        end
    end
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // Checks
    chk_susp_clears_latch: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        $rose(program_suspended_flag_q | erase_suspended_flag_q)
        |-> !write_latch_q)
        else $error("write latch set after suspend");
    chk_chip_no_susp: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        op_kind_q == OPK_CHIP |-> eng_q != ST_SUSPENDING)
        else $error("chip erase was suspended");
    chk_flag_busy: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        $rose(erase_suspended_flag_q) |-> busy_flag)
        else $error("erase suspend not busy at flag set");
    chk_resume_clears: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        suspended && accept && is_res_op |=> !program_suspended_flag_q
        && !erase_suspended_flag_q && eng_q == ST_RUN)
        else $error("resume did not restart");
    chk_sleep_only_wake: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        slp_q == SL_ASLEEP && accept |-> op == OP_WAKE_ID)
        else $error("opcode taken while asleep");
    chk_quad_entry: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        accept && op == OP_QUAD_ENTRY |=> quad_command_mode_q)
        else $error("quad entry not taken");
    chk_quad_exit: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        accept && op == OP_QUAD_EXIT && quad_command_mode_q && exact_len
        |=> !quad_command_mode_q)
        else $error("quad exit not taken");
    chk_susp_rejects: assert property (
        @(posedge I_SYS_CLK) disable iff (I_RESET)
        suspended && (op == OP_STATUS_WRITE || is_erase(op)) |-> !accept)
        else $error("write taken during suspend");
endmodule

// [verification/fmsp_host_model.sv]
// Host model: drives select, serial clock and data for one opcode
`timescale 1ns/1ps
module fmsp_host_model (
    // Serial pins toward the device
    output logic o_sel_n,
    output logic o_sck,
    output logic [3:0] o_io
);
    // Idle: deselected, clock parked low
    initial begin
        o_sel_n = 1'b1;
        o_sck = 1'b0;
        o_io = 4'h0;
    end

    // One framed opcode; the clock only runs inside the frame
    task automatic send(input logic [7:0] op, input bit quad,
                        input int nclk);
        logic [7:0] sh;
        sh = op;
        o_sel_n = 1'b0;
        #62.5;
        for (int i = 0; i < nclk; i++) begin
            if (quad) begin
                o_io = sh[7:4];
                sh = {sh[3:0], 4'h0};
            end else begin
                o_io = {~o_io[3:1], sh[7]};
                sh = {sh[6:0], 1'b0};
            end
            #62.5 o_sck = 1'b1;
            #62.5 o_sck = 1'b0;
        end
        o_sel_n = 1'b1;
        // Lines inverted once at frame end so a stale value is never mistaken for data
        o_io = ~o_io;
        #300;
    endtask
endmodule

// [verification/testbench.sv]
// Testbench: quad mode, suspend and resume, deep sleep
`timescale 1ns/1ps
module testbench;
    import fmsp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic eng_done = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic sel_n;
    logic sck;
    logic [3:0] io;
    logic eng_run;
    logic [1:0] eng_kind;
    logic [31:0] hrdata;
    logic hrdy;
    logic hresp;
    logic cmd_valid;
    logic [7:0] cmd_code;
    int n_acc = 0;
    // Resume-to-suspend gap the host keeps: 80 us at 100 MHz
    localparam int RESUME_GAP = 8000;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    bit qm = 0;

    // Short counts keep the run brief
    fmsp_ctrl #(.SUSPEND_CYCLES(20), .SLEEP_CYCLES(5), .WAKE_CYCLES(5)) dut (
        .I_SYS_CLK(clk), .I_RESET(rst), .I_SEL_N(sel_n), .I_SCK(sck),
        .I_IO(io), .I_ENG_DONE(eng_done), .O_ENG_RUN(eng_run),
        .O_ENG_KIND(eng_kind), .O_CMD_VALID(cmd_valid), .O_CMD_CODE(cmd_code),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
        .HREADYOUT(hrdy), .HRESP(hresp));
    fmsp_host_model host (.o_sel_n(sel_n), .o_sck(sck), .o_io(io));

    // 100 MHz clock and a hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) n_acc <= n_acc + 1;
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize;
        $display("mismatches %0d, checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    // Wait for the slave's ready; only the bench timeout ends it
    task automatic wait_rdy;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
    endtask

    // One single-word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(n, e & m, d & m);
    endtask

    function automatic logic [31:0] st(bit s, bit q, bit l, bit b);
        st = 32'h0;
        st[BIT_SLEEP] = s;
        st[BIT_QUAD] = q;
        st[BIT_WLATCH] = l;
        st[BIT_BUSY] = b;
    endfunction

    task automatic op(input logic [7:0] c);
        host.send(c, qm, qm ? 2 : 8);
    endtask

    // Polls busy; twenty reads span twice the 20-cycle settle time
    task automatic wait_idle;
        logic [31:0] d;
        int n;
        n = 0;
        d = 32'h1;
        while (d[BIT_BUSY] !== 1'b0 && n < 20) begin
            ahb(1'b0, REG_STATUS, 32'h0, d);
            n++;
        end
        chk("settled", 32'h0, {31'h0, d[BIT_BUSY]});
    endtask

    task automatic done_pulse;
        @(posedge clk);
        eng_done <= 1'b1;
        @(posedge clk);
        eng_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset;
        logic [31:0] d;
        rd_chk("status", REG_STATUS, 32'h0, '1);
        rd_chk("func", REG_FUNC, 32'h0, '1);
        ahb(1'b1, REG_CTRL, 32'h1, d);
        rd_chk("ctrl", REG_CTRL, 32'h1, '1);
        ahb(1'b1, 8'h10, 32'hFFFFFFFF, d);
        rd_chk("unmapped", 8'h10, 32'h0, '1);
        chk("resp", 32'h0, {31'h0, hresp});
    endtask

    // Program suspend in one-bit mode, refusals, then two resumes
    task automatic t_prog;
        logic [7:0] bad[4] = '{OP_STATUS_WRITE, OP_SERIAL_PAGE,
                               OP_LATCH_SET, 8'hC4};
        op(OP_LATCH_SET);
        rd_chk("latch", REG_STATUS, st(0, 0, 1, 0), '1);
        op(OP_SERIAL_PAGE);
        chk("kind", 32'h1, {30'h0, eng_kind});
        rd_chk("busy", REG_STATUS, st(0, 0, 0, 1), '1);
        op(OP_SUSPEND_A);
        rd_chk("program_suspended_flag", REG_FUNC, 32'h4, '1);
        wait_idle();
        rd_chk("wl", REG_STATUS, st(0, 0, 0, 0), '1);
        foreach (bad[i]) begin
            op(bad[i]);
            rd_chk("p_ref", REG_LASTOP, 32'h75, 32'hFF);
        end
        op(8'h03);
        rd_chk("rd", REG_LASTOP, 32'h03, 32'hFF);
        chk("code", 32'h03, {24'h0, cmd_code});
        op(OP_STATUS_READ);
        rd_chk("sr", REG_LASTOP, 32'h05, 32'hFF);
        op(OP_RESUME_A);
        rd_chk("p_res", REG_FUNC, 32'h0, '1);
        rd_chk("p_bsy", REG_STATUS, st(0, 0, 0, 1), '1);
        chk("run", 32'h1, {31'h0, eng_run});
        // Host keeps the resume-to-suspend gap before suspending again
        repeat (RESUME_GAP) @(posedge clk);
        op(OP_SUSPEND_B);
        rd_chk("psus2", REG_FUNC, 32'h4, '1);
        wait_idle();
        op(OP_RESUME_B);
        rd_chk("p_res2", REG_FUNC, 32'h0, '1);
        done_pulse();
        rd_chk("p_end", REG_STATUS, st(0, 0, 0, 0), '1);
    endtask

    // Erase suspend with the second opcodes, all in quad mode
    task automatic t_erase;
        logic [7:0] bad[3] = '{OP_STATUS_WRITE, OP_SECTOR_ER_B,
                               OP_BLOCK64_ER};
        op(OP_QUAD_ENTRY);
        qm = 1;
        rd_chk("quad", REG_STATUS, st(0, 1, 0, 0), '1);
        op(OP_LATCH_SET);
        op(OP_SECTOR_ER_A);
        chk("kind", 32'h2, {30'h0, eng_kind});
        op(OP_SUSPEND_B);
        rd_chk("erase_suspended_flag", REG_FUNC, 32'h8, '1);
        wait_idle();
        foreach (bad[i]) begin
            op(bad[i]);
            rd_chk("e_ref", REG_LASTOP, 32'hB0, 32'hFF);
        end
        op(OP_LATCH_SET);
        rd_chk("e_wl", REG_STATUS, st(0, 1, 1, 0), '1);
        op(8'hEB);
        rd_chk("qrd", REG_LASTOP, 32'hEB, 32'hFF);
        op(OP_RESUME_B);
        rd_chk("e_res", REG_FUNC, 32'h0, '1);
        done_pulse();
        rd_chk("e_end", REG_STATUS, 32'h0, 32'h1);
        host.send(OP_QUAD_EXIT, 1'b1, 4);
        rd_chk("no_x", REG_STATUS, 32'h10, 32'h10);
        op(OP_QUAD_EXIT);
        qm = 0;
        rd_chk("exit", REG_STATUS, 32'h0, 32'h10);
    endtask

    // Chip erase: suspend opcode dropped, no accept strobe
    task automatic t_chip;
        int n;
        op(OP_LATCH_SET);
        op(OP_CHIP_ER_A);
        chk("kind", 32'h3, {30'h0, eng_kind});
        n = n_acc;
        op(OP_SUSPEND_A);
        chk("c_acc", n, n_acc);
        rd_chk("c_sus", REG_FUNC, 32'h0, '1);
        rd_chk("c_op", REG_LASTOP, 32'hC7, 32'hFF);
        done_pulse();
        rd_chk("c_end", REG_STATUS, 32'h0, 32'h1);
    endtask

    // Deep sleep entered and left in quad mode
    task automatic t_sleep;
        int n;
        op(OP_QUAD_ENTRY);
        qm = 1;
        op(OP_SLEEP);
        rd_chk("slp", REG_STATUS, 32'h30, '1);
        n = n_acc;
        op(OP_STATUS_READ);
        rd_chk("s_ign", REG_LASTOP, 32'hB9, 32'hFF);
        op(OP_LATCH_SET);
        rd_chk("s_wl", REG_STATUS, 32'h30, '1);
        op(OP_WAKE_ID);
        chk("s_acc", n + 1, n_acc);
        repeat (10) @(posedge clk);
        rd_chk("wake", REG_STATUS, 32'h10, '1);
        op(OP_QUAD_EXIT);
        qm = 0;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_prog();
        t_erase();
        t_chip();
        t_sleep();
        summarize();
    end
endmodule
